// >>> verilog/rsp_pkg.sv
// constants shared by the row sub-sample and pixel output chain
// assumes a single 250 MHz clock and pulse-type sequencing inputs
package rsp_pkg;
  localparam int CLK_MHZ = 250;
  localparam int ROW_W = 10;
  localparam int CODE_W = 10;
  localparam int GAIN_W = 4;
  localparam int OFS_W = 7;
  localparam int AMP_W = 7;
  localparam int CFG_W = 8;
  localparam int PIX_W = 11;
  localparam int GX_W = 11;
  // image-core configuration bit positions
  localparam int CFG_DECIM_BIT = 5;
  localparam int CFG_SWAP1_BIT = 6;
  localparam int CFG_SWAP2_BIT = 7;
  // row pointer steps and group layout
  localparam logic [ROW_W-1:0] ROW_STEP = 10'h001;
  localparam logic [ROW_W-1:0] ROW_PAIR_SKIP = 10'h003;
  localparam logic [1:0] GRP_ROW0 = 2'h0;
  localparam logic [1:0] GRP_ROW1 = 2'h1;
  localparam logic [1:0] GRP_ROW2 = 2'h2;
  localparam logic [1:0] GRP_ROW3 = 2'h3;
  // analog settle time after a pixel step
  localparam int SETTLE_NS = 20;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [2:0] SETTLE_LOAD = 3'(SETTLE_CYC - 1);
  localparam logic [2:0] SETTLE_LAST = 3'h1;
  // converter nominal rate and pipeline depth
  localparam int CONV_MSPS = 40;
  localparam int CONV_LAT = 2;
  // non-linear law, coefficients scaled by 1000 (a = 5, b = 0.027)
  localparam logic [39:0] GAMMA_A = 40'd5000;
  localparam logic [39:0] GAMMA_B = 40'd27;
  localparam logic [39:0] CODE_FULL = 40'd1023;
  localparam logic [39:0] GAMMA_DEN = GAMMA_A * CODE_FULL + GAMMA_B * CODE_FULL * CODE_FULL;
  // dc gain per code, times 100
  localparam logic [GX_W-1:0] GAIN_X100 [16] = '{
    11'd137, 11'd162, 11'd196, 11'd233, 11'd276, 11'd350, 11'd425, 11'd520,
    11'd625, 11'd789, 11'd921, 11'd1100, 11'd1137, 11'd1184, 11'd1232, 11'd1242};
  localparam logic [GAIN_W-1:0] GAIN_MID_CODE = 4'h8;
endpackage : rsp_pkg

// >>> verilog/rsp_row_pixel_chain.sv
// row pointer sub-sampling, amplifier setting latch, pixel settle timing and converter pipeline
// assumes all inputs synchronous to mclk_i; conv_clk_i is the converter clock level, sampled here
//
// What this block does
// - no decimation: pointer advances one row
// - decimation, no swap: pattern XXOOXXOO
// - first swap only: pattern XOXOXOXO
// - second swap only: pattern OXOXOXOX
// - both swaps: pattern OOXXOOXX
// - decimation: only pairs 0-1, 4-5 addressable
// - 4-bit gain code, exponential steps
// - 7-bit offset codes, linear between references
// - gain 1.37 at 0000 to 12.42
// - coarse common offset, fine even/odd offset
// - pixel step, output settles 20 ns later
// - converter word two converter cycles later
// - one 10-bit sample per conversion clock
// - linear or dark-expanding non-linear law
// - non-linear law with a=5, b=0.027
// - decimate and swaps are config bits 5-7
// - gain in low bits of amplifier setting
`timescale 1ns/100ps
module rsp_row_pixel_chain (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [rsp_pkg::CFG_W-1:0] core_cfg_i,
  input wire logic [rsp_pkg::AMP_W-1:0] amp_setting_i,
  input wire logic [rsp_pkg::OFS_W-1:0] coarse_offset_code_i,
  input wire logic [rsp_pkg::OFS_W-1:0] fine_offset_code_i,
  input wire logic gamma_enable_i,
  input wire logic frame_start_i,
  input wire logic [rsp_pkg::ROW_W-1:0] row_start_i,
  input wire logic row_step_i,
  input wire logic pixel_step_i,
  input wire logic conv_clk_i,
  input wire logic [rsp_pkg::CODE_W-1:0] conv_level_i,
  output logic [rsp_pkg::ROW_W-1:0] row_select_o,
  output logic row_decimate_enable_o,
  output logic [rsp_pkg::GAIN_W-1:0] gain_code_o,
  output logic [rsp_pkg::GX_W-1:0] gain_x100_o,
  output logic [rsp_pkg::OFS_W-1:0] coarse_offset_code_o,
  output logic [rsp_pkg::OFS_W-1:0] fine_offset_code_o,
  output logic [rsp_pkg::PIX_W-1:0] pixel_count_o,
  output logic amp_settled_o,
  output logic [rsp_pkg::CODE_W-1:0] pixel_word_o,
  output logic pixel_word_valid_o
);
  import rsp_pkg::*;

  // row map: first swap exchanges group rows 1 and 2, second swap exchanges rows 0 and 3
  function automatic logic [ROW_W-1:0] row_map(input logic [ROW_W-1:0] p, input logic s1, input logic s2);
    logic [1:0] g;
    g = p[1:0];
    if (s1 && g == GRP_ROW1) begin
      g = GRP_ROW2;
    end else if (s1 && g == GRP_ROW2) begin
      g = GRP_ROW1;
    end
    if (s2 && g == GRP_ROW0) begin
      g = GRP_ROW3;
    end else if (s2 && g == GRP_ROW3) begin
      g = GRP_ROW0;
    end
    return {p[ROW_W-1:2], g};
  endfunction : row_map

  // successive approximation of the largest code whose level does not exceed the input
  function automatic logic [CODE_W-1:0] gamma_code(input logic [CODE_W-1:0] lvl);
    logic [CODE_W-1:0] x;
    logic [39:0] xw;
    logic [39:0] lhs;
    logic [39:0] rhs;
    x = '0;
    xw = '0;
    lhs = '0;
    rhs = 40'(lvl) * GAMMA_DEN;
    for (int i = CODE_W - 1; i >= 0; i--) begin
      x[i] = 1'b1;
      xw = {30'h0, x};
      lhs = (GAMMA_A * xw + GAMMA_B * xw * xw) * CODE_FULL;
      if (lhs > rhs) begin
        x[i] = 1'b0;
      end
    end
    return x;
  endfunction : gamma_code

  logic [ROW_W-1:0] row_ptr_reg;
  logic [ROW_W-1:0] row_ptr_next;
  logic decim_reg;
  logic swap1_reg;
  logic swap2_reg;
  logic [2:0] settle_cnt_reg;
  logic [CODE_W-1:0] stage0_reg;
  logic [CODE_W-1:0] stage1_reg;
  logic [CONV_LAT-1:0] vld_pipe_reg;
  logic conv_clk_d_reg;

  wire frame_decim = core_cfg_i[CFG_DECIM_BIT];
  wire frame_swap1 = core_cfg_i[CFG_SWAP1_BIT];
  wire frame_swap2 = core_cfg_i[CFG_SWAP2_BIT];
  wire decim_next = frame_start_i ? frame_decim : decim_reg;
  wire swap1_next = frame_start_i ? frame_swap1 : swap1_reg;
  wire swap2_next = frame_start_i ? frame_swap2 : swap2_reg;
  wire [ROW_W-1:0] start_aligned = {row_start_i[ROW_W-1:2], GRP_ROW0};
  wire [ROW_W-1:0] ptr_plain = row_ptr_reg + ROW_STEP;
  wire [ROW_W-1:0] ptr_decim = row_ptr_reg[0] ? row_ptr_reg + ROW_PAIR_SKIP : ptr_plain;
  wire [ROW_W-1:0] row_select_next = decim_next ? row_map(row_ptr_next, swap1_next, swap2_next) : row_ptr_next;
  wire row_boundary = frame_start_i | row_step_i;
  wire [GAIN_W-1:0] gain_next = row_boundary ? amp_setting_i[GAIN_W-1:0] : gain_code_o;
  wire conv_edge = conv_clk_i & ~conv_clk_d_reg;
  wire [CODE_W-1:0] conv_word = gamma_enable_i ? gamma_code(conv_level_i) : conv_level_i;
  wire settled_next = ~pixel_step_i & ((settle_cnt_reg == SETTLE_LAST) | amp_settled_o);

  always_comb begin
    row_ptr_next = row_ptr_reg;
    if (frame_start_i) begin
      row_ptr_next = frame_decim ? start_aligned : row_start_i;
    end else if (row_step_i) begin
      row_ptr_next = decim_reg ? ptr_decim : ptr_plain;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      row_ptr_reg <= '0;
      decim_reg <= 1'b0;
      swap1_reg <= 1'b0;
      swap2_reg <= 1'b0;
      row_select_o <= '0;
      row_decimate_enable_o <= 1'b0;
    end else begin
      row_ptr_reg <= row_ptr_next;
      decim_reg <= decim_next;
      swap1_reg <= swap1_next;
      swap2_reg <= swap2_next;
      row_select_o <= row_select_next;
      row_decimate_enable_o <= decim_next;
    end
  end

  // amplifier settings held for the whole row
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      gain_code_o <= '0;
      gain_x100_o <= GAIN_X100[0];
      coarse_offset_code_o <= '0;
      fine_offset_code_o <= '0;
    end else begin
      gain_code_o <= gain_next;
      gain_x100_o <= GAIN_X100[gain_next];
      if (row_boundary) begin
        coarse_offset_code_o <= coarse_offset_code_i;
        fine_offset_code_o <= fine_offset_code_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      settle_cnt_reg <= '0;
      amp_settled_o <= 1'b0;
      pixel_count_o <= '0;
    end else begin
      if (pixel_step_i) begin
        settle_cnt_reg <= SETTLE_LOAD;
      end else if (settle_cnt_reg != '0) begin
        settle_cnt_reg <= settle_cnt_reg - SETTLE_LAST;
      end
      amp_settled_o <= settled_next;
      if (row_boundary) begin
        pixel_count_o <= '0;
      end else if (pixel_step_i) begin
        pixel_count_o <= pixel_count_o + 11'h001;
      end
    end
  end

  // converter pipeline: sample, one stage, output, all on converter clock edges
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      conv_clk_d_reg <= 1'b0;
      stage0_reg <= '0;
      stage1_reg <= '0;
      vld_pipe_reg <= '0;
      pixel_word_o <= '0;
      pixel_word_valid_o <= 1'b0;
    end else begin
      conv_clk_d_reg <= conv_clk_i;
      pixel_word_valid_o <= conv_edge & vld_pipe_reg[1];
      if (conv_edge) begin
        stage0_reg <= conv_word;
        stage1_reg <= stage0_reg;
        pixel_word_o <= stage1_reg;
        vld_pipe_reg <= {vld_pipe_reg[0], 1'b1};
      end
    end
  end

  property p_row_plain;
    @(posedge mclk_i) disable iff (!rst_n_i)
    row_step_i && !frame_start_i && !decim_reg |=> row_ptr_reg == $past(row_ptr_reg) + ROW_STEP;
  endproperty
  a_row_plain: assert property (p_row_plain) else $error("row pointer did not advance by one");
  property p_pat_base;
    @(posedge mclk_i) disable iff (!rst_n_i)
    decim_reg && !swap1_reg && !swap2_reg |-> row_select_o[1] == 1'b0;
  endproperty
  a_pat_base: assert property (p_pat_base) else $error("base decimation selected rows 2 or 3");
  property p_pat_swap1;
    @(posedge mclk_i) disable iff (!rst_n_i)
    decim_reg && swap1_reg && !swap2_reg |-> row_select_o[0] == 1'b0;
  endproperty
  a_pat_swap1: assert property (p_pat_swap1) else $error("first swap selected an odd row");
  property p_pat_swap2;
    @(posedge mclk_i) disable iff (!rst_n_i)
    decim_reg && !swap1_reg && swap2_reg |-> row_select_o[0] == 1'b1;
  endproperty
  a_pat_swap2: assert property (p_pat_swap2) else $error("second swap selected an even row");
  property p_pat_both;
    @(posedge mclk_i) disable iff (!rst_n_i)
    decim_reg && swap1_reg && swap2_reg |-> row_select_o[1] == 1'b1;
  endproperty
  a_pat_both: assert property (p_pat_both) else $error("both swaps selected rows 0 or 1");
  property p_pair_addr;
    @(posedge mclk_i) disable iff (!rst_n_i)
    decim_reg |-> row_ptr_reg[1] == 1'b0;
  endproperty
  a_pair_addr: assert property (p_pair_addr) else $error("pointer left the addressable pairs");
  property p_settle;
    @(posedge mclk_i) disable iff (!rst_n_i)
    pixel_step_i ##1 (!pixel_step_i)[*4] |=> amp_settled_o && !$past(amp_settled_o);
  endproperty
  a_settle: assert property (p_settle) else $error("settle flag not raised five cycles after step");
  property p_gain_hold;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !row_boundary |=> $stable(gain_code_o) && $stable(coarse_offset_code_o) && $stable(fine_offset_code_o);
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("amplifier setting changed inside a row");
  property p_gain_mid;
    @(posedge mclk_i) disable iff (!rst_n_i)
    gain_code_o == GAIN_MID_CODE |-> gain_x100_o == 11'd625;
  endproperty
  a_gain_mid: assert property (p_gain_mid) else $error("mid gain code not 6.25");
  property p_conv_lat;
    @(posedge mclk_i) disable iff (!rst_n_i)
    conv_edge |=> pixel_word_o == $past(stage1_reg) && stage1_reg == $past(stage0_reg);
  endproperty
  a_conv_lat: assert property (p_conv_lat) else $error("converter pipeline did not shift on an edge");
  property p_word_hold;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !conv_edge |=> $stable(pixel_word_o);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("pixel word changed between converter edges");
  property p_valid_idle;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !conv_edge |=> !pixel_word_valid_o;
  endproperty
  a_valid_idle: assert property (p_valid_idle) else $error("word valid raised without a converter edge");
  property p_valid_third;
    @(posedge mclk_i) disable iff (!rst_n_i)
    conv_edge && vld_pipe_reg[1] |=> pixel_word_valid_o;
  endproperty
  a_valid_third: assert property (p_valid_third) else $error("filled pipeline gave no word valid");
  property p_start_align;
    @(posedge mclk_i) disable iff (!rst_n_i)
    frame_start_i && frame_decim |=> row_ptr_reg[1:0] == GRP_ROW0 && row_decimate_enable_o;
  endproperty
  a_start_align: assert property (p_start_align) else $error("decimated frame started off a pair");
  property p_decim_skip;
    @(posedge mclk_i) disable iff (!rst_n_i)
    row_step_i && !frame_start_i && decim_reg && row_ptr_reg[0] |=> row_ptr_reg == $past(row_ptr_reg) + ROW_PAIR_SKIP;
  endproperty
  a_decim_skip: assert property (p_decim_skip) else $error("decimation did not skip two rows");
  property p_gain_table;
    @(posedge mclk_i) disable iff (!rst_n_i)
    gain_x100_o == GAIN_X100[gain_code_o];
  endproperty
  a_gain_table: assert property (p_gain_table) else $error("dc gain does not match gain code");
  property p_settle_drop;
    @(posedge mclk_i) disable iff (!rst_n_i)
    pixel_step_i |=> !amp_settled_o;
  endproperty
  a_settle_drop: assert property (p_settle_drop) else $error("settle flag stayed high over a pixel step");
  property p_count_clear;
    @(posedge mclk_i) disable iff (!rst_n_i)
    row_boundary |=> pixel_count_o == '0;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("pixel count not cleared at row boundary");
  property p_cfg_hold;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !frame_start_i |=> $stable(row_decimate_enable_o);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("decimation mode changed inside a frame");
  property p_valid_edge;
    @(posedge mclk_i) disable iff (!rst_n_i)
    pixel_word_valid_o |-> $past(conv_edge) && $past(vld_pipe_reg[1]);
  endproperty
  a_valid_edge: assert property (p_valid_edge) else $error("word valid without a converter edge");
  property p_linear;
    @(posedge mclk_i) disable iff (!rst_n_i)
    conv_edge && !gamma_enable_i |=> stage0_reg == $past(conv_level_i);
  endproperty
  a_linear: assert property (p_linear) else $error("linear law did not pass the level");
  c_decim_both: cover property (@(posedge mclk_i) decim_reg && swap1_reg && swap2_reg && row_step_i);
  c_word_out: cover property (@(posedge mclk_i) pixel_word_valid_o && gamma_enable_i);
  c_settled: cover property (@(posedge mclk_i) $rose(amp_settled_o));
  c_decim_base: cover property (@(posedge mclk_i) decim_reg && !swap1_reg && !swap2_reg && row_step_i);
  c_word_lin: cover property (@(posedge mclk_i) pixel_word_valid_o && !gamma_enable_i);
endmodule : rsp_row_pixel_chain

// >>> sim/rsp_ctrl_model.sv
// camera controller model: converter clock with adjustable phase and a ramping converter input level
// assumes mclk_i free running; outputs change 1 ns after its rising edge; half_i is at least 2
`timescale 1ns/100ps
module rsp_ctrl_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic [2:0] half_i,
  input wire logic [2:0] phase_i,
  output logic conv_clk_o,
  output logic [rsp_pkg::CODE_W-1:0] conv_level_o
);
  import rsp_pkg::*;
  int cnt = 0;
  int pos = 0;
  always @(posedge mclk_i) begin
    #1;
    if (!rst_n_i || !en_i) begin
      // clock stands still while the converter is idle
      cnt = 0;
      conv_clk_o = 1'b0;
      if (!rst_n_i) conv_level_o = 10'h000;
    end else begin
      cnt = cnt + 1;
      pos = (cnt + int'(phase_i)) % (2 * int'(half_i));
      conv_clk_o = (pos < int'(half_i));
      // level moves only on the low phase, away from the sampling edge
      if (pos == int'(half_i)) conv_level_o = conv_level_o + 10'h0b7;
    end
  end
endmodule : rsp_ctrl_model

// >>> sim/tb_top.sv
// self-checking bench for the row pointer and pixel output chain
// assumes rsp_pkg and rsp_row_pixel_chain compiled first; inputs change 1 ns after the clock edge
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import rsp_pkg::*;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, gamma_enable_i = 1'b0, frame_start_i = 1'b0;
  logic row_step_i = 1'b0, pixel_step_i = 1'b0, conv_clk_i, en = 1'b0, cprev = 1'b0;
  logic [7:0] core_cfg_i = 8'h00;
  logic [6:0] amp_setting_i = 7'h00, coarse_offset_code_i = 7'h00, fine_offset_code_i = 7'h00;
  logic [9:0] row_start_i = 10'h000, conv_level_i, row_select_o, pixel_word_o, w;
  logic row_decimate_enable_o, amp_settled_o, pixel_word_valid_o;
  logic [3:0] gain_code_o;
  logic [10:0] gain_x100_o, pixel_count_o;
  logic [6:0] coarse_offset_code_o, fine_offset_code_o;
  logic [2:0] half = 3'h2, phase = 3'h1;
  logic [9:0] conv_q[$];
  int err_count = 0, n_checks = 0, n_valid = 0, n_edge = 0;
  rsp_row_pixel_chain rsp_row_pixel_chain_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .core_cfg_i(core_cfg_i),
    .amp_setting_i(amp_setting_i), .coarse_offset_code_i(coarse_offset_code_i),
    .fine_offset_code_i(fine_offset_code_i), .gamma_enable_i(gamma_enable_i), .frame_start_i(frame_start_i),
    .row_start_i(row_start_i), .row_step_i(row_step_i), .pixel_step_i(pixel_step_i), .conv_clk_i(conv_clk_i),
    .conv_level_i(conv_level_i), .row_select_o(row_select_o), .row_decimate_enable_o(row_decimate_enable_o),
    .gain_code_o(gain_code_o), .gain_x100_o(gain_x100_o), .coarse_offset_code_o(coarse_offset_code_o),
    .fine_offset_code_o(fine_offset_code_o), .pixel_count_o(pixel_count_o), .amp_settled_o(amp_settled_o),
    .pixel_word_o(pixel_word_o), .pixel_word_valid_o(pixel_word_valid_o));
  rsp_ctrl_model rsp_ctrl_model_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .en_i(en), .half_i(half),
    .phase_i(phase), .conv_clk_o(conv_clk_i), .conv_level_o(conv_level_i));
  always #2 mclk_i = ~mclk_i;
  function automatic logic [9:0] phys(logic [9:0] l, logic [7:0] c);
    logic [1:0] p;
    p = l[1:0];
    if (c[5] && c[6] && p == 2'h1) p = 2'h2;
    if (c[5] && c[7] && p == 2'h0) p = 2'h3;
    return {l[9:2], p};
  endfunction : phys
  function automatic logic [9:0] expw(logic [9:0] v, logic g);
    longint d;
    d = 64'd5000 * 1023 + 64'd27 * 1023 * 1023;
    expw = v;
    if (g) for (longint x = 0; x < 1024; x++) if ((5000 * x + 27 * x * x) * 1023 <= v * d) expw = 10'(x);
  endfunction : expw
  always @(posedge mclk_i) begin
    if (pixel_word_valid_o === 1'b1) begin
      n_valid++;
      `CHK(3'(conv_q.size()), 3'h3)
      if (conv_q.size() > 0) begin
        w = conv_q.pop_front();
        `CHK(pixel_word_o, w)
      end
    end
    if (rst_n_i && conv_clk_i && !cprev) begin
      conv_q.push_back(expw(conv_level_i, gamma_enable_i));
      n_edge++;
    end
    cprev = conv_clk_i;
  end
  task automatic results();
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic run_rows(input logic [7:0] c, input logic [9:0] s);
    logic [9:0] l;
    l = c[5] ? {s[9:2], 2'h0} : s;
    core_cfg_i = c;
    row_start_i = s;
    frame_start_i = 1'b1;
    @(posedge mclk_i) #1;
    frame_start_i = 1'b0;
    core_cfg_i = ~c;
    row_step_i = 1'b1;
    `CHK(row_decimate_enable_o, c[5])
    for (int i = 0; i < 6; i++) begin
      `CHK(row_select_o, phys(l, c))
      @(posedge mclk_i) #1;
      l = (c[5] && l[0]) ? l + ROW_PAIR_SKIP : l + ROW_STEP;
    end
    row_step_i = 1'b0;
  endtask : run_rows
  task automatic run_gain();
    logic [10:0] tbl[16] = '{137, 162, 196, 233, 276, 350, 425, 520, 625, 789, 921, 1100, 1137, 1184, 1232, 1242};
    logic [3:0] pg;
    logic [6:0] pc;
    logic [6:0] pf;
    pg = 4'h0;
    pc = 7'h00;
    pf = 7'h00;
    for (int g = 0; g < 16; g++) begin
      amp_setting_i = {3'h5, 4'(g)};
      coarse_offset_code_i = 7'(g * 8 + 1);
      fine_offset_code_i = 7'(127 - g);
      @(posedge mclk_i) #1;
      `CHK(gain_code_o, pg)
      `CHK(coarse_offset_code_o, pc)
      `CHK(fine_offset_code_o, pf)
      row_step_i = 1'b1;
      @(posedge mclk_i) #1;
      row_step_i = 1'b0;
      `CHK(gain_code_o, 4'(g))
      `CHK(gain_x100_o, tbl[g])
      `CHK(coarse_offset_code_o, 7'(g * 8 + 1))
      `CHK(fine_offset_code_o, 7'(127 - g))
      pg = 4'(g);
      pc = 7'(g * 8 + 1);
      pf = 7'(127 - g);
    end
  endtask : run_gain
  task automatic run_settle();
    for (int k = 1; k < 3; k++) begin
      pixel_step_i = 1'b1;
      @(posedge mclk_i) #1;
      pixel_step_i = 1'b0;
      `CHK(pixel_count_o, 11'(k))
      for (int i = 1; i < 6; i++) begin
        `CHK(amp_settled_o, 1'(i == 5))
        if (i < 5) @(posedge mclk_i) #1;
      end
    end
    row_step_i = 1'b1;
    @(posedge mclk_i) #1;
    row_step_i = 1'b0;
    `CHK(pixel_count_o, 11'h000)
  endtask : run_settle
  task automatic run_conv(input logic [2:0] h, input logic [2:0] ph);
    half = h;
    phase = ph;
    // the converter pipeline keeps its words across idle spans, so queue and counts run on
    en = 1'b1;
    repeat (60) @(posedge mclk_i);
    #1 gamma_enable_i = 1'b1;
    repeat (60) @(posedge mclk_i);
    #1 en = 1'b0;
    gamma_enable_i = 1'b0;
    repeat (12) @(posedge mclk_i);
    #1 `CHK(n_valid, n_edge - 2)
  endtask : run_conv
  initial begin
    repeat (6) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    `CHK(gain_x100_o, 11'd137)
    run_rows(8'h00, 10'h1f3);
    run_rows(8'h20, 10'h017);
    run_rows(8'h60, 10'h017);
    run_rows(8'ha0, 10'h3fa);
    run_rows(8'he0, 10'h102);
    run_gain();
    run_settle();
    run_conv(3'h2, 3'h1);
    run_conv(3'h3, 3'h4);
    results();
  end
  initial begin
    #20000;
    err_count++;
    results();
  end
endmodule : tb_top
